// ### dv/timing_output_selector_bench.sv
`timescale 1ns/1ps
module timing_output_selector_bench;
   logic        clk = 1'b0;
   logic        rstn = 1'b0;
   logic [12:0] src = 13'h1555;
   logic [5:0]  fmt = 6'h01;
   logic [3:0]  awaddr = 4'h0, araddr = 4'h0;
   logic [31:0] wdata = 32'h0, rdata;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic        awready, wready, bvalid, arready, rvalid;
   logic [1:0]  bresp, rresp;
   logic [5:0]  tout, oen, drv, pin;
   int          fail_count = 0;
   int          comparisons = 0;
   always #2.5 clk = ~clk;
   timing_output_selector DUT (.REF_CLK(clk), .RESETN(rstn), .HSYNC(src[0]),
      .HBLANK(src[1]), .VSYNC(src[2]), .VBLANK(src[3]), .FSYNC(src[4]), .FDIGITAL(src[5]),
      .DISPLAY_EN(src[6]), .FILM_CADENCE_FIELD_ID(src[7]), .AUDIO_FRAME_SYNC_PULSE(src[8]),
      .USER_TIMING(src[12:9]), .VIDEO_FORMAT_SELECT(fmt), .TIMING_OUT(tout),
      .TIMING_OE_N(oen), .TIMING_DRIVE_HIGH(drv), .S_AXI_AWADDR(awaddr),
      .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
      .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
      .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
      .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
      .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
      .S_AXI_RREADY(rready));
   tos_sink sink (.clk(clk), .out(tout), .oe_n(oen), .pin(pin));
   task chk(input logic [31:0] s, input logic [31:0] e);
      comparisons++;
      if (s !== e) begin
         fail_count++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, s, e);
      end
   endtask
   task wr(input logic [3:0] a, input logic [31:0] d);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge clk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while ((awvalid && !awready) || (wvalid && !wready));
      do @(posedge clk); while (!bvalid);
      bready <= 1'b0;
      chk(bresp, 32'h0);
   endtask
   task rdc(input logic [3:0] a, input logic [31:0] e);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge clk); while (!arready);
      arvalid <= 1'b0;
      do @(posedge clk); while (!rvalid);
      rready <= 1'b0;
      chk(rdata, e);
   endtask
   function logic pick(input logic [12:0] s, input logic [3:0] c);
      return (c < 4'hd) ? s[c] : 1'b0;
   endfunction
   task final_report;
      $display("Mismatches %0d of %0d comparisons", fail_count, comparisons);
      if (fail_count == 0 && comparisons > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   initial begin
      #20000;
      fail_count++;
      final_report;
   end
   initial begin
      repeat (3) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      rdc(4'h0, 32'h3210);
      rdc(4'h4, 32'h54);
      rdc(4'h8, 32'h0);
      for (int p = 0; p < 2; p++) begin
         src <= p ? 13'h1555 : 13'h0aaa;
         @(posedge clk);
         #1 chk(tout, {26'h0, ~src[5:0]});
         @(posedge clk);
         #1 chk(pin, src[5:0]);
         @(posedge clk);
      end
      for (int c = 0; c < 16; c++) begin
         wr(4'h0, {16'h0, {4{c[3:0]}}});
         wr(4'h4, {24'h0, {2{c[3:0]}}});
         for (int p = 0; p < 2; p++) begin
            src <= p ? 13'h1555 : 13'h0aaa;
            repeat (3) @(posedge clk);
            chk(pin, {6{pick(src, c[3:0])}});
         end
      end
      rdc(4'h0, 32'hffff);
      wr(4'h8, 32'h2a);
      @(posedge clk);
      chk(drv, 6'h2a);
      rdc(4'h8, 32'h2a);
      wr(4'hc, 32'hff);
      rdc(4'hc, 32'h01);
      fmt <= 6'h00;
      repeat (6) @(posedge clk);
      chk(oen, 6'h3f);
      rdc(4'hc, 32'h40);
      fmt <= 6'h3f;
      repeat (6) @(posedge clk);
      chk(oen, 6'h00);
      rstn <= 1'b0;
      @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      chk(drv, 6'h00);
      rdc(4'h0, 32'h3210);
      final_report;
   end
endmodule

// ### dv/tos_chk.sv
`timescale 1ns/1ps
// ****************
// Port checker
// ****************
module tos_chk (
   input logic        REF_CLK,
   input logic        RESETN,
   input logic [5:0]  VIDEO_FORMAT_SELECT,
   input logic [5:0]  TIMING_OE_N,
   input logic [5:0]  TIMING_DRIVE_HIGH,
   input logic        S_AXI_BVALID,
   input logic        S_AXI_BREADY,
   input logic [1:0]  S_AXI_BRESP,
   input logic        S_AXI_ARVALID,
   input logic        S_AXI_ARREADY,
   input logic        S_AXI_RVALID,
   input logic        S_AXI_RREADY,
   input logic [31:0] S_AXI_RDATA,
   input logic [1:0]  S_AXI_RRESP
);
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (!RESETN);
   // The select pins pass two sync flops, a compare and the output flop.
   pins_released_a: assert property ((RESETN && VIDEO_FORMAT_SELECT == 6'h00) [*4] |=>
      TIMING_OE_N == 6'h3f) else $error("pins driven at format zero");
   pins_driven_a: assert property ((RESETN && VIDEO_FORMAT_SELECT != 6'h00) [*4] |=>
      TIMING_OE_N == 6'h00) else $error("pins released at live format");
   drive_reset_a: assert property ($rose(RESETN) |-> TIMING_DRIVE_HIGH == 6'h00)
      else $error("drive not low after reset");
   drive_by_host_a: assert property (!$stable(TIMING_DRIVE_HIGH) |-> $past(S_AXI_BVALID))
      else $error("drive changed without a write");
   bresp_hold_a: assert property (S_AXI_BVALID && !S_AXI_BREADY |=>
      S_AXI_BVALID && $stable(S_AXI_BRESP)) else $error("write answer dropped");
   rdata_hold_a: assert property (S_AXI_RVALID && !S_AXI_RREADY |=>
      S_AXI_RVALID && $stable(S_AXI_RDATA)) else $error("read answer dropped");
   read_after_addr_a: assert property ($rose(S_AXI_RVALID) |->
      $past(S_AXI_ARVALID && S_AXI_ARREADY)) else $error("read answer without address");
   resp_okay_a: assert property (S_AXI_BVALID || S_AXI_RVALID |->
      (S_AXI_BRESP | S_AXI_RRESP) == 2'h0) else $error("error response");
endmodule

bind timing_output_selector tos_chk u_chk (.REF_CLK, .RESETN, .VIDEO_FORMAT_SELECT,
   .TIMING_OE_N, .TIMING_DRIVE_HIGH, .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_BRESP,
   .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RVALID, .S_AXI_RREADY, .S_AXI_RDATA,
   .S_AXI_RRESP);

// ### dv/tos_sink.sv
`timescale 1ns/1ps
// ****************
// Downstream pins
// ****************
module tos_sink (
   input  logic       clk,
   input  logic [5:0] out,
   input  logic [5:0] oe_n,
   output logic [5:0] pin
);
   logic [5:0] t_q = 6'h00;
   // A released pin floats, so a toggling level keeps a stale value from passing.
   always @(posedge clk) t_q <= ~t_q;
   assign pin = (out & ~oe_n) | (t_q & oe_n);
endmodule

// ### hdl/src_pick.v
`timescale 1ns/1ps
`include "tmux_defs.vh"

// *****************************
// Registered source selector
// *****************************
module src_pick (
   // Clock and reset
   input  wire        clk,
   input  wire        rst_n,
   // Sources and select
   input  wire [12:0] src,
   input  wire [3:0]  sel,
   // Result
   output reg         pin_q
);

   // Unused codes give a quiet low rather than an arbitrary source.
   function pick;
      input [12:0] s;
      input [3:0]  c;
      begin
         if (c <= `SRC_USER4) begin
            pick = s[c];
         end else begin
            pick = 1'b0;
         end
      end
   endfunction

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_q <= 1'b0;
      end else begin
         pin_q <= pick(src, sel);
      end
   end

endmodule

// ### hdl/timing_output_selector.v
`timescale 1ns/1ps
`include "tmux_defs.vh"

module timing_output_selector (
   // Clock and reset
   input  wire        REF_CLK,
   input  wire        RESETN,
   // Timing sources from the generator
   input  wire        HSYNC,
   input  wire        HBLANK,
   input  wire        VSYNC,
   input  wire        VBLANK,
   input  wire        FSYNC,
   input  wire        FDIGITAL,
   input  wire        DISPLAY_EN,
   input  wire        FILM_CADENCE_FIELD_ID,
   input  wire        AUDIO_FRAME_SYNC_PULSE,
   input  wire [3:0]  USER_TIMING,
   // Format select pins
   input  wire [5:0]  VIDEO_FORMAT_SELECT,
   // Timing pins
   output reg  [5:0]  TIMING_OUT,
   output reg  [5:0]  TIMING_OE_N,
   output reg  [5:0]  TIMING_DRIVE_HIGH,
   // AXI4-Lite write address
   input  wire [3:0]  S_AXI_AWADDR,
   input  wire        S_AXI_AWVALID,
   output reg         S_AXI_AWREADY,
   // AXI4-Lite write data
   input  wire [31:0] S_AXI_WDATA,
   input  wire [3:0]  S_AXI_WSTRB,
   input  wire        S_AXI_WVALID,
   output reg         S_AXI_WREADY,
   // AXI4-Lite write response
   output reg  [1:0]  S_AXI_BRESP,
   output reg         S_AXI_BVALID,
   input  wire        S_AXI_BREADY,
   // AXI4-Lite read address
   input  wire [3:0]  S_AXI_ARADDR,
   input  wire        S_AXI_ARVALID,
   output reg         S_AXI_ARREADY,
   // AXI4-Lite read data
   output reg  [31:0] S_AXI_RDATA,
   output reg  [1:0]  S_AXI_RRESP,
   output reg         S_AXI_RVALID,
   input  wire        S_AXI_RREADY
);

   // *****************************
   // Input synchronisers
   // *****************************
   reg  [5:0]  fmt_meta_q;
   reg  [5:0]  fmt_q;
   reg         hiz_q;
   wire [12:0] src;
   wire [5:0]  pick_q;
   reg  [23:0] sel_q;
   reg  [5:0]  drive_q;
   reg         aw_q;
   reg         w_q;
   reg  [3:0]  awaddr_q;
   reg  [31:0] wdata_q;
   reg  [3:0]  wstrb_q;
   reg  [31:0] rd_d;
   reg  [1:0]  rresp_d;
   wire [31:0] sel_lo_m;
   wire [31:0] sel_hi_m;
   wire [31:0] drive_m;
   genvar      g;

   // The format pins are asynchronous, so only the second stage is looked at.
   always @(posedge REF_CLK or negedge RESETN) begin
      if (!RESETN) begin
         fmt_meta_q <= 6'h00;
         fmt_q      <= 6'h00;
         hiz_q      <= 1'b1;
      end else begin
         fmt_meta_q <= VIDEO_FORMAT_SELECT;
         fmt_q      <= fmt_meta_q;
         hiz_q      <= (fmt_q == 6'h00);
      end
   end

   assign src = {USER_TIMING, AUDIO_FRAME_SYNC_PULSE, FILM_CADENCE_FIELD_ID, DISPLAY_EN,
                 FDIGITAL, FSYNC, VBLANK, VSYNC, HBLANK, HSYNC};

   // *****************************
   // Per-pin selection
   // *****************************
   generate
      for (g = 0; g < `NUM_PINS; g = g + 1) begin : pin
         src_pick u_pick (
            .clk   (REF_CLK),
            .rst_n (RESETN),
            .src   (src),
            .sel   (sel_q[g*`SEL_W +: `SEL_W]),
            .pin_q (pick_q[g])
         );
      end
   endgenerate

   // The pick stage already registers the pin; this stage lines it up with the
   // enable so a pin never drives stale data as it leaves high impedance.
   always @(posedge REF_CLK or negedge RESETN) begin
      if (!RESETN) begin
         TIMING_OUT        <= 6'h00;
         TIMING_OE_N       <= 6'h3f;
         TIMING_DRIVE_HIGH <= `DRIVE_RESET;
      end else begin
         TIMING_OUT        <= pick_q;
         TIMING_OE_N       <= {6{hiz_q}};
         TIMING_DRIVE_HIGH <= drive_q;
      end
   end

   // *****************************
   // Register bus, write side
   // *****************************
   function [31:0] merge;
      input [31:0] old;
      input [31:0] dat;
      input [3:0]  stb;
      integer      i;
      begin
         merge = old;
         for (i = 0; i < 4; i = i + 1) begin
            if (stb[i]) begin
               merge[i*8 +: 8] = dat[i*8 +: 8];
            end
         end
      end
   endfunction

   // Both bus sides decode only the word part of the address.
   function [3:0] word_ofs;
      input [3:0] a;
      begin
         word_ofs = {a[3:2], 2'b00};
      end
   endfunction

   // Byte lanes are merged into the stored words before they are cut to width.
   assign sel_lo_m = merge({16'h0000, sel_q[15:0]}, wdata_q, wstrb_q);
   assign sel_hi_m = merge({24'h000000, sel_q[23:16]}, wdata_q, wstrb_q);
   assign drive_m  = merge({26'h0000000, drive_q}, wdata_q, wstrb_q);

   always @(posedge REF_CLK or negedge RESETN) begin
      if (!RESETN) begin
         aw_q          <= 1'b0;
         w_q           <= 1'b0;
         awaddr_q      <= 4'h0;
         wdata_q       <= 32'h00000000;
         wstrb_q       <= 4'h0;
         S_AXI_AWREADY <= 1'b0;
         S_AXI_WREADY  <= 1'b0;
         S_AXI_BVALID  <= 1'b0;
         S_AXI_BRESP   <= `RESP_OKAY;
         sel_q         <= `SEL_RESET;
         drive_q       <= `DRIVE_RESET;
      end else begin
         S_AXI_AWREADY <= !aw_q && !S_AXI_AWREADY && !S_AXI_BVALID && S_AXI_AWVALID;
         S_AXI_WREADY  <= !w_q && !S_AXI_WREADY && !S_AXI_BVALID && S_AXI_WVALID;
         if (S_AXI_AWVALID && S_AXI_AWREADY) begin
            aw_q     <= 1'b1;
            awaddr_q <= S_AXI_AWADDR;
         end
         if (S_AXI_WVALID && S_AXI_WREADY) begin
            w_q     <= 1'b1;
            wdata_q <= S_AXI_WDATA;
            wstrb_q <= S_AXI_WSTRB;
         end
         if (aw_q && w_q && !S_AXI_BVALID) begin
            aw_q         <= 1'b0;
            w_q          <= 1'b0;
            S_AXI_BVALID <= 1'b1;
            S_AXI_BRESP  <= `RESP_OKAY;
            case (word_ofs(awaddr_q))
               `SEL_LO_OFS: begin
                  sel_q[15:0] <= sel_lo_m[15:0];
               end
               `SEL_HI_OFS: begin
                  sel_q[23:16] <= sel_hi_m[7:0];
               end
               `DRIVE_OFS: begin
                  drive_q <= drive_m[5:0];
               end
               `STATUS_OFS: begin
                  S_AXI_BRESP <= `RESP_OKAY;
               end
               default: begin
                  S_AXI_BRESP <= `RESP_SLVERR;
               end
            endcase
         end
         if (S_AXI_BVALID && S_AXI_BREADY) begin
            S_AXI_BVALID <= 1'b0;
         end
      end
   end

   // *****************************
   // Register bus, read side
   // *****************************
   always @* begin
      rd_d    = 32'h00000000;
      rresp_d = `RESP_OKAY;
      case (word_ofs(S_AXI_ARADDR))
         `SEL_LO_OFS: rd_d = {16'h0000, sel_q[15:0]};
         `SEL_HI_OFS: rd_d = {24'h000000, sel_q[23:16]};
         `DRIVE_OFS:  rd_d = {26'h0000000, drive_q};
         `STATUS_OFS: rd_d = {25'h0000000, hiz_q, fmt_q};
         default:     rresp_d = `RESP_SLVERR;
      endcase
   end

   always @(posedge REF_CLK or negedge RESETN) begin
      if (!RESETN) begin
         S_AXI_ARREADY <= 1'b0;
         S_AXI_RVALID  <= 1'b0;
         S_AXI_RDATA   <= 32'h00000000;
         S_AXI_RRESP   <= `RESP_OKAY;
      end else begin
         S_AXI_ARREADY <= !S_AXI_ARREADY && !S_AXI_RVALID && S_AXI_ARVALID;
         if (S_AXI_ARVALID && S_AXI_ARREADY) begin
            S_AXI_RVALID <= 1'b1;
            S_AXI_RDATA  <= rd_d;
            S_AXI_RRESP  <= rresp_d;
         end else if (S_AXI_RVALID && S_AXI_RREADY) begin
            S_AXI_RVALID <= 1'b0;
         end
      end
   end

endmodule

// ### hdl/tmux_defs.vh
// Functional notes
// - Each pin picks one source: syncs, blankings, fields, DE, cadence, audio, four user.
// - Each pin has a host-set drive strength, low after reset.
// - All pins go high impedance while format select equals zero.
// - Pin one defaults to horizontal sync after reset.
// - Pin two defaults to horizontal blanking after reset.
// - Pin three defaults to vertical sync after reset.
// - Pin four defaults to vertical blanking after reset.
// - Pin five defaults to field sync after reset.
// - Pin six defaults to field digital after reset.
`ifndef TMUX_DEFS_VH
`define TMUX_DEFS_VH

// Register byte offsets.
`define SEL_LO_OFS    4'h0
`define SEL_HI_OFS    4'h4
`define DRIVE_OFS     4'h8
`define STATUS_OFS    4'hc

// Source codes.
`define SRC_HSYNC     4'h0
`define SRC_HBLANK    4'h1
`define SRC_VSYNC     4'h2
`define SRC_VBLANK    4'h3
`define SRC_FSYNC     4'h4
`define SRC_FDIG      4'h5
`define SRC_DE        4'h6
`define SRC_CADENCE   4'h7
`define SRC_AFS       4'h8
`define SRC_USER1     4'h9
`define SRC_USER2     4'ha
`define SRC_USER3     4'hb
`define SRC_USER4     4'hc

// Reset value of the packed select word, four bits per pin, pin one lowest.
`define SEL_RESET     24'h543210
`define DRIVE_RESET   6'h00
`define SEL_W         4
`define NUM_PINS      6

// AXI responses.
`define RESP_OKAY     2'h0
`define RESP_SLVERR   2'h2

`endif
